/* core/cti_pkg.sv */
// contour trajectory interpolator: shared constants and types
// assumes one 100 MHz controller clock shared by both ends
package cti_pkg;
  localparam int NUM_AXES = 4;
  localparam int INC_W = 16;
  localparam int POS_W = 32;
  localparam int ACC_W = 25;
  localparam int EXP_W = 4;
  localparam int CNT_W = 9;
  localparam int ADDR_W = 3;

  localparam logic [EXP_W-1:0] EXP_MAX = 4'h8;
  localparam logic [EXP_W-1:0] EXP_EXIT = 4'h0;
  localparam logic signed [INC_W-1:0] INC_LIMIT = 16'sh7D00;
  localparam logic [7:0] ERR_CHAR = 8'h3F;

  // 1 ms interpolation tick
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // controller register word indexes
  localparam logic [ADDR_W-1:0] REG_CMD = 3'h0;
  localparam logic [ADDR_W-1:0] REG_INC_LO = 3'h1;
  localparam logic [ADDR_W-1:0] REG_INC_HI = 3'h2;
  localparam logic [ADDR_W-1:0] REG_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 3'h5;

  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WAIT_BIT = 2;
  localparam int CMD_EXP_LSB = 4;
  localparam int CMD_AXES_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_BUF_BIT = 1;
  localparam int ST_ERRCH_LSB = 8;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;

  localparam logic [31:0] INC_RESET = 32'h0000_0000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  typedef enum logic [1:0] {CTI_OP_SELECT, CTI_OP_EXP, CTI_OP_INC} cti_op_t;
endpackage

/* core/cti_link_if.sv */
// link between the segment issuer (host end) and the interpolator (device end)
// assumes both ends run on the same clock; no crossing inside
`timescale 1ns/1ps
interface cti_link_if;
  import cti_pkg::*;
  logic rec_valid;
  cti_op_t rec_op;
  logic [NUM_AXES-1:0] rec_axes;
  logic [EXP_W-1:0] rec_exp;
  logic [NUM_AXES-1:0][INC_W-1:0] rec_inc;
  logic rec_wait;
  logic rec_ready;
  logic err_valid;
  logic [7:0] err_char;
  logic contour_buffer_flag;

  modport dev (
    input rec_valid, rec_op, rec_axes, rec_exp, rec_inc, rec_wait,
    output rec_ready, err_valid, err_char, contour_buffer_flag
  );
  modport host (
    output rec_valid, rec_op, rec_axes, rec_exp, rec_inc, rec_wait,
    input rec_ready, err_valid, err_char, contour_buffer_flag
  );
endinterface

/* core/cti_dev_end.sv */
// contour interpolator: takes segment records, emits one point per ms per selected axis
// assumes the host end holds a record steady until rec_ready pulses
`timescale 1ns/1ps

// Notes on behaviour
// - only selected axes of four contour
// - segment lasts two to the n ms
// - linear interpolation, one point per ms
// - signed increments within plus/minus 32000
// - zero exponent then zero increment exits
// - wait flag holds records until segment done
// - no data means no new points
// - bad record answered with question mark
// - last exponent kept for later increments
// - no limit on segment count; length at most 256 ms
// - buffer flag shows a pending record
module cti_dev_end #(
  parameter int TICK_CYCLES = cti_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  cti_link_if.dev link,
  output logic signed [cti_pkg::POS_W-1:0] pos_out [cti_pkg::NUM_AXES],
  output logic [cti_pkg::NUM_AXES-1:0] point_out,
  output logic [cti_pkg::NUM_AXES-1:0] contour_axes_out,
  output logic contour_active_out
);
  import cti_pkg::*;

  typedef enum logic [1:0] {CTI_S_IDLE, CTI_S_WAIT, CTI_S_RUN} cti_state_t;

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

  cti_state_t state_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic rec_ready_q;
  logic err_valid_q;
  logic [7:0] err_char_q;
  logic [EXP_W-1:0] exp_q;
  logic pend_q;
  logic pend_exit_q;
  logic [EXP_W-1:0] pend_exp_q;
  logic [NUM_AXES-1:0][INC_W-1:0] pend_inc_q;
  logic [EXP_W-1:0] run_exp_q;
  logic [NUM_AXES-1:0][INC_W-1:0] run_inc_q;
  logic [CNT_W-1:0] cnt_q;
  logic wait_blk_q;
  logic [NUM_AXES-1:0] rng_bad;
  logic [NUM_AXES-1:0] inc_nz;
  logic take;
  logic bad;
  logic good;
  logic [CNT_W-1:0] seg_last;
  logic seg_end;
  logic load;

  ////////////////////////////////////////////////////////////////////////////
  // free running millisecond tick

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TICK_LAST) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // record acceptance and checking

  // no take during a ready pulse: the host drops valid only after it
  always_comb begin
    take = link.rec_valid && !rec_ready_q && !wait_blk_q;
    if (link.rec_op == CTI_OP_INC && pend_q) begin
      take = 1'b0;
    end
    case (link.rec_op)
      CTI_OP_SELECT: begin
        bad = (state_q != CTI_S_IDLE) || (link.rec_axes == '0);
      end
      CTI_OP_EXP: begin
        bad = link.rec_exp > EXP_MAX;
      end
      CTI_OP_INC: begin
        // nonzero motion with a zero exponent has no defined interval
        bad = (state_q == CTI_S_IDLE) || (|rng_bad) ||
              ((exp_q == EXP_EXIT) && (|inc_nz));
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    good = take && !bad;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rec_ready_q <= 1'b0;
      err_valid_q <= 1'b0;
      err_char_q <= 8'h00;
    end else begin
      rec_ready_q <= take;
      err_valid_q <= take && bad;
      err_char_q <= (take && bad) ? ERR_CHAR : 8'h00;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      exp_q <= EXP_EXIT;
    end else if (good && link.rec_op == CTI_OP_EXP) begin
      exp_q <= link.rec_exp;
    end
  end

  // single record slot between issuer and running segment
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_q <= 1'b0;
      pend_exit_q <= 1'b0;
      pend_exp_q <= EXP_EXIT;
      pend_inc_q <= '0;
    end else if (good && link.rec_op == CTI_OP_INC) begin
      pend_q <= 1'b1;
      pend_exit_q <= exp_q == EXP_EXIT;
      pend_exp_q <= exp_q;
      pend_inc_q <= link.rec_inc;
    end else if (load) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wait_blk_q <= 1'b0;
    end else if (good && link.rec_op == CTI_OP_INC && link.rec_wait) begin
      wait_blk_q <= 1'b1;
    end else if (!pend_q && (seg_end || state_q != CTI_S_RUN)) begin
      wait_blk_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // segment sequencer

  always_comb begin
    seg_last = (9'h001 << run_exp_q) - 9'h001;
    seg_end = tick_q && (state_q == CTI_S_RUN) && (cnt_q == seg_last);
    load = pend_q && ((state_q == CTI_S_WAIT) || seg_end);
  end

  // segments chain forever while records keep coming
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= CTI_S_IDLE;
      contour_axes_out <= '0;
      run_exp_q <= EXP_EXIT;
      run_inc_q <= '0;
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= '0;
      run_exp_q <= pend_exp_q;
      run_inc_q <= pend_inc_q;
      if (pend_exit_q) begin
        state_q <= CTI_S_IDLE;
        contour_axes_out <= '0;
      end else begin
        state_q <= CTI_S_RUN;
      end
    end else begin
      case (state_q)
        CTI_S_IDLE: begin
          if (good && link.rec_op == CTI_OP_SELECT) begin
            state_q <= CTI_S_WAIT;
            contour_axes_out <= link.rec_axes;
          end
        end
        CTI_S_RUN: begin
          if (seg_end) begin
            state_q <= CTI_S_WAIT;
          end else if (tick_q) begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        CTI_S_WAIT: begin
          state_q <= CTI_S_WAIT;
        end
        default: begin
          state_q <= CTI_S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      contour_active_out <= 1'b0;
    end else begin
      contour_active_out <= (state_q != CTI_S_IDLE) || load;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per axis interpolation

  for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
    logic signed [INC_W-1:0] inc_in;
    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W-1:0] acc_nx;
    logic signed [ACC_W-1:0] acc_sh;
    logic signed [POS_W-1:0] start_q;
    logic signed [POS_W-1:0] pos_nx;
    logic step;

    assign inc_in = $signed(link.rec_inc[a]);
    assign rng_bad[a] = (inc_in > INC_LIMIT) || (inc_in < -INC_LIMIT);
    assign inc_nz[a] = |link.rec_inc[a];
    // unselected axes never step, so other modes keep them
    assign step = tick_q && (state_q == CTI_S_RUN) && contour_axes_out[a];

    // position is start plus floor(k*inc / 2^n): the remainder rides in acc
    always_comb begin
      acc_nx = acc_q + {{(ACC_W - INC_W){run_inc_q[a][INC_W-1]}}, run_inc_q[a]};
      acc_sh = acc_nx >>> run_exp_q;
      pos_nx = start_q + {{(POS_W - ACC_W){acc_sh[ACC_W-1]}}, acc_sh};
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        acc_q <= '0;
        start_q <= '0;
      end else if (load) begin
        acc_q <= '0;
        start_q <= step ? pos_nx : pos_out[a];
      end else if (step) begin
        acc_q <= acc_nx;
      end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        pos_out[a] <= '0;
        point_out[a] <= 1'b0;
      end else begin
        point_out[a] <= step;
        if (step) begin
          pos_out[a] <= pos_nx;
        end
      end
    end
  end

  assign link.rec_ready = rec_ready_q;
  assign link.err_valid = err_valid_q;
  assign link.err_char = err_char_q;
  assign link.contour_buffer_flag = pend_q;
endmodule

/* core/cti_host_end.sv */
// segment issuer: software registers turned into link records
// assumes the device end on the same clock answers each record with rec_ready
`timescale 1ns/1ps
module cti_host_end (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  cti_link_if.host link,
  input wire logic [cti_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out
);
  import cti_pkg::*;

  logic valid_q;
  cti_op_t op_q;
  logic [NUM_AXES-1:0] axes_q;
  logic [EXP_W-1:0] exp_q;
  logic wait_q;
  logic [NUM_AXES-1:0][INC_W-1:0] inc_q;
  logic [31:0] inc_lo_q;
  logic [31:0] inc_hi_q;
  logic [7:0] err_char_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_ev;
  logic [31:0] rd_v;
  logic cmd_wr;

  ////////////////////////////////////////////////////////////////////////////
  // record issue

  // a command written while one is outstanding is dropped
  assign cmd_wr = reg_wr_in && reg_addr_in == REG_CMD && !valid_q;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_q <= 1'b0;
      op_q <= CTI_OP_SELECT;
      axes_q <= '0;
      exp_q <= EXP_EXIT;
      wait_q <= 1'b0;
      inc_q <= '0;
    end else if (cmd_wr) begin
      valid_q <= 1'b1;
      op_q <= cti_op_t'(reg_wdata_in[CMD_OP_LSB +: 2]);
      wait_q <= reg_wdata_in[CMD_WAIT_BIT];
      exp_q <= reg_wdata_in[CMD_EXP_LSB +: EXP_W];
      axes_q <= reg_wdata_in[CMD_AXES_LSB +: NUM_AXES];
      inc_q <= {inc_hi_q, inc_lo_q};
    end else if (valid_q && link.rec_ready) begin
      valid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      inc_lo_q <= INC_RESET;
      inc_hi_q <= INC_RESET;
    end else if (reg_wr_in && reg_addr_in == REG_INC_LO) begin
      inc_lo_q <= reg_wdata_in;
    end else if (reg_wr_in && reg_addr_in == REG_INC_HI) begin
      inc_hi_q <= reg_wdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt

  assign irq_ev[IRQ_DONE_BIT] = valid_q && link.rec_ready && !link.err_valid;
  assign irq_ev[IRQ_ERR_BIT] = link.err_valid;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= IRQ_MASK_RESET;
      err_char_q <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      // a new event beats a same-cycle clear
      if (reg_wr_in && reg_addr_in == REG_IRQ_STAT) begin
        irq_stat_q <= (irq_stat_q & ~reg_wdata_in[1:0]) | irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (reg_wr_in && reg_addr_in == REG_IRQ_MASK) begin
        irq_mask_q <= reg_wdata_in[1:0];
      end
      if (link.err_valid) begin
        err_char_q <= link.err_char;
      end
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_comb begin
    rd_v = 32'h0000_0000;
    case (reg_addr_in)
      REG_CMD: begin
        rd_v[CMD_OP_LSB +: 2] = op_q;
        rd_v[CMD_WAIT_BIT] = wait_q;
        rd_v[CMD_EXP_LSB +: EXP_W] = exp_q;
        rd_v[CMD_AXES_LSB +: NUM_AXES] = axes_q;
      end
      REG_INC_LO: rd_v = inc_lo_q;
      REG_INC_HI: rd_v = inc_hi_q;
      REG_STATUS: begin
        rd_v[ST_BUSY_BIT] = valid_q;
        rd_v[ST_BUF_BIT] = link.contour_buffer_flag;
        rd_v[ST_ERRCH_LSB +: 8] = err_char_q;
      end
      REG_IRQ_STAT: rd_v[1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_v[1:0] = irq_mask_q;
      default: rd_v = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_v : 32'h0000_0000;
    end
  end

  assign link.rec_valid = valid_q;
  assign link.rec_op = op_q;
  assign link.rec_axes = axes_q;
  assign link.rec_exp = exp_q;
  assign link.rec_inc = inc_q;
  assign link.rec_wait = wait_q;
endmodule

/* dv/cti_chk.sv */
// link checker: error answers, exponent range, pending flag
// assumes one clock; placed beside the link interface by the bench
`timescale 1ns/1ps
module cti_chk (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic rec_valid,
  input cti_pkg::cti_op_t rec_op,
  input wire logic [cti_pkg::EXP_W-1:0] rec_exp,
  input wire logic rec_ready,
  input wire logic err_valid,
  input wire logic [7:0] err_char,
  input wire logic contour_buffer_flag
);
  import cti_pkg::*;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  ////////////////////////////////////////
  sequence s_exp_taken;
    rec_ready && rec_op == CTI_OP_EXP;
  endsequence
  sequence s_inc_ok;
    rec_ready && rec_op == CTI_OP_INC && !err_valid;
  endsequence
  // only an accepted segment may fill the slot
  property p_flag_cause;
    $rose(contour_buffer_flag) |-> rec_ready && rec_op == CTI_OP_INC;
  endproperty
  ////////////////////////////////////////
  chk_err_char_on: assert property (err_valid |-> err_char == ERR_CHAR)
    else $error("error pulse without question mark");
  chk_err_char_off: assert property (!err_valid |-> err_char == 8'h00)
    else $error("error char outside error pulse");
  chk_err_has_ready: assert property (err_valid |-> rec_ready)
    else $error("error pulse without record taken");
  chk_bad_op: assert property (rec_ready && rec_op == 2'h3 |-> err_valid)
    else $error("unknown op accepted");
  chk_exp_range: assert property (s_exp_taken ##0 rec_exp > EXP_MAX |-> err_valid)
    else $error("exponent above eight accepted");
  chk_exp_kept: assert property (s_exp_taken ##0 rec_exp <= EXP_MAX |-> !err_valid)
    else $error("legal exponent refused");
  chk_inc_flag: assert property (s_inc_ok |-> contour_buffer_flag ##1 !rec_ready)
    else $error("accepted segment not flagged");
  chk_flag_cause: assert property (p_flag_cause)
    else $error("pending flag rose without segment");
  chk_ready_offered: assert property (rec_ready |-> rec_valid)
    else $error("record answered without being offered");
  chk_ready_single: assert property (rec_ready |=> !rec_ready)
    else $error("record answered twice");
endmodule

/* dv/test_contour_trajectory_interpolator.sv */
// bench: host end and device end joined by the link, plus link checker
// assumes a tick of 8 clocks so segments stay short
`timescale 1ns/1ps
module test_contour_trajectory_interpolator;
  import cti_pkg::*;
  logic sys_clk, arst_n, wr, rd, irq, act, e;
  logic [2:0] addr;
  logic [31:0] wdata, rdata, d;
  logic signed [31:0] pos [4];
  logic [3:0] pt, axo, sel;
  localparam int TB_TICK = 8;
  int n_errors, samples_checked, mn, gap;
  int mi [4];
  int ms [4];
  int mk [4];
  cti_link_if cti_link_if_i ();
  cti_dev_end #(.TICK_CYCLES(TB_TICK)) cti_dev_end_i (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .link(cti_link_if_i), .pos_out(pos), .point_out(pt), .contour_axes_out(axo),
    .contour_active_out(act));
  cti_host_end cti_host_end_i (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .link(cti_link_if_i), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq));
  cti_chk cti_chk_i (.sys_clk_in(sys_clk), .arst_n_in(arst_n),
    .rec_valid(cti_link_if_i.rec_valid), .rec_op(cti_link_if_i.rec_op),
    .rec_exp(cti_link_if_i.rec_exp), .rec_ready(cti_link_if_i.rec_ready),
    .err_valid(cti_link_if_i.err_valid), .err_char(cti_link_if_i.err_char),
    .contour_buffer_flag(cti_link_if_i.contour_buffer_flag));
  always #5 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  function automatic logic [31:0] cw(logic [1:0] op, logic w, logic [3:0] n, logic [3:0] ax);
    return {20'h0, ax, n, 1'b0, w, op};
  endfunction
  // floor of k*inc/2^n keeps the remainder, so the last point lands exactly
  function automatic int pexp(int a);
    return ms[a] + ((mk[a] * mi[a]) >>> mn);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // issue one record and wait for its answer; a wait flag may hold it long
  task automatic go(input logic [31:0] c);
    int i;
    wr_reg(REG_CMD, c);
    for (i = 0; i < 5000 && cti_link_if_i.rec_ready !== 1'b1; i++) @(negedge sys_clk);
    if (i == 5000) chk(1'b0, 1'b1);
    e = cti_link_if_i.err_valid;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic seg(input int s);
    logic [3:0] n2;
    int i;
    for (i = 0; i < 4; i++) mi[i] = int'($urandom_range(64000)) - 32000;
    if (s == 0) begin
      mi[0] = 48;
      mi[1] = 32000;
      mi[2] = -32000;
    end
    wr_reg(REG_INC_LO, {mi[1][15:0], mi[0][15:0]});
    wr_reg(REG_INC_HI, {mi[3][15:0], mi[2][15:0]});
    go(cw(CTI_OP_INC, 1'b1, 4'h0, 4'h0));
    chk(e, 1'b0);
    if (s[0]) begin
      n2 = (s == 1) ? 4'h8 : 4'($urandom_range(3, 1));
      go(cw(CTI_OP_EXP, 1'b0, n2, 4'h0));
      chk(mk[0], 32'h1 << mn);
      mn = n2;
    end else begin
      for (i = 0; i < 5000 && mk[0] != (1 << mn); i++) @(negedge sys_clk);
      chk(mk[0], 32'h1 << mn);
    end
    for (i = 0; i < 4; i++) begin
      if (sel[i]) ms[i] += mi[i];
      mk[i] = 0;
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // points of one run come one tick apart; the first of a run is not timed
  always @(negedge sys_clk) begin
    gap++;
    for (int a = 0; a < 4; a++) begin
      if (pt[a] === 1'b1) begin
        mk[a]++;
        chk(sel[a], 1'b1);
        chk(pos[a], pexp(a));
        if (a == 0 && mk[0] > 1) chk(gap, TB_TICK);
        if (a == 0) gap = 0;
      end
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    chk(1'b0, 1'b1);
    results();
  end
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    addr = 3'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    mn = 2;
    sel = 4'h0;
    mi = '{default: 0};
    ms = '{default: 0};
    mk = '{default: 0};
    void'($urandom(76599));
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_reg(REG_STATUS);
    chk(d, 32'h0);
    rd_reg(REG_IRQ_MASK);
    chk(d, 32'h0);
    rd_reg(3'h7);
    chk(d, 32'h0);
    go(cw(CTI_OP_INC, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b1);
    chk(irq, 1'b0);
    wr_reg(REG_IRQ_MASK, 32'h3);
    repeat (2) @(negedge sys_clk);
    chk(irq, 1'b1);
    rd_reg(REG_IRQ_STAT);
    chk(d[1], 1'b1);
    wr_reg(REG_IRQ_STAT, 32'h3);
    rd_reg(REG_IRQ_STAT);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    // axis 0 always joins so segment lengths can be timed on it
    sel = 4'($urandom_range(15)) | 4'h1;
    go(cw(CTI_OP_SELECT, 1'b0, 4'h0, sel));
    chk(axo, sel);
    chk(act, 1'b1);
    go(cw(CTI_OP_SELECT, 1'b0, 4'h0, 4'hF));
    chk(e, 1'b1);
    chk(axo, sel);
    go(cw(2'h3, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b1);
    go(cw(CTI_OP_EXP, 1'b0, 4'h9, 4'h0));
    chk(e, 1'b1);
    go(cw(CTI_OP_EXP, 1'b0, 4'h2, 4'h0));
    chk(e, 1'b0);
    wr_reg(REG_INC_LO, 32'h0000_7D01);
    go(cw(CTI_OP_INC, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b1);
    for (int s = 0; s < 4; s++) seg(s);
    repeat (40) @(negedge sys_clk);
    chk(mk[0], 32'h0);
    // same record twice without wait: the second loads on the first's last tick
    go(cw(CTI_OP_EXP, 1'b0, 4'h3, 4'h0));
    chk(e, 1'b0);
    mn = 3;
    go(cw(CTI_OP_INC, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b0);
    go(cw(CTI_OP_INC, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b0);
    rd_reg(REG_STATUS);
    chk(d[ST_BUF_BIT], 1'b1);
    for (int i = 0; i < 5000 && mk[0] != (2 << mn); i++) @(negedge sys_clk);
    chk(mk[0], 32'h2 << mn);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) ms[i] += 2 * mi[i];
      mk[i] = 0;
    end
    go(cw(CTI_OP_EXP, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b0);
    // motion under a zero exponent has no interval
    go(cw(CTI_OP_INC, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b1);
    wr_reg(REG_INC_LO, 32'h0);
    wr_reg(REG_INC_HI, 32'h0);
    go(cw(CTI_OP_INC, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b0);
    repeat (10) @(negedge sys_clk);
    chk(act, 1'b0);
    chk(axo, 4'h0);
    chk(pos[0], ms[0]);
    for (int a = 0; a < 4; a++) chk(pos[a], ms[a]);
    go(cw(CTI_OP_SELECT, 1'b0, 4'h0, 4'h0));
    chk(e, 1'b1);
    results();
  end
endmodule
